/* File: rtl/cas_params.svh */
// Purpose: offsets, field positions, resets and counts
// Assumes: included by bare name
// Notes:   definitions only
`ifndef CAS_PARAMS_SVH
`define CAS_PARAMS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CAS_OFF_STATUS   12'h000
`define CAS_OFF_CTRL     12'h004
`define CAS_OFF_IRQ_STS  12'h008
`define CAS_OFF_IRQ_CLR  12'h00c
`define CAS_OFF_IRQ_EN   12'h010
// ----------------------------------------
// status bit positions and resets
// ----------------------------------------
`define CAS_BIT_LOS      1
`define CAS_BIT_LOL      2
`define CAS_BIT_FL       3
`define CAS_BIT_ALOS     4
`define CAS_STATUS_RST   8'h00
`define CAS_CTRL_RST     4'h0
// ----------------------------------------
// counts
// ----------------------------------------
`define CAS_DLOS_RUN     8'd160
`define CAS_DENS_WIN     6'd32
`define CAS_DENS_MIN     6'd11
`define CAS_FIFO_DEPTH   6'd32
`define CAS_FIFO_MID     6'd16
`define CAS_FIFO_MARGIN  6'd2
`define CAS_LOL_WIN      12'd2000
`define CAS_LOL_PPM      5000
`define CAS_LOL_TOL      12'd10
`endif

/* File: rtl/cas_pkg.sv */
// Purpose: shared types of the channel alarm status block
// Assumes: nothing
// Notes:   constants live in cas_params.svh
package cas_pkg;
	typedef enum logic [1:0] {
		RATE_E3,
		RATE_DS3,
		RATE_STS1
	} cas_rate_t;

	// software control word
	typedef struct packed {
		logic      single_freq_mode;
		logic      ja_enable;
		cas_rate_t rate;
	} cas_ctrl_t;

	// line side pins, each a level from outside pclk
	typedef struct packed {
		logic amp_below_declare;
		logic amp_above_clear;
		logic rx_bit_tick;
		logic rx_pulse;
		logic ja_read_tick;
		logic e3_ref_clock_in;
		logic ds3_ref_clock_in;
		logic sts1_ref_clock_in;
		logic synth_ref_tick;
	} cas_line_t;

	typedef enum logic {
		DLOS_CLEAR,
		DLOS_DECLARED
	} cas_dlos_t;
endpackage

/* File: rtl/cas_top.sv */
// Purpose: per-channel alarm status bits behind an APB slave
// Assumes: line pins are slow against pclk (40 MHz)
// Notes:   one instance per channel; status is read-only
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
`include "cas_params.svh"

module cas_top (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire cas_pkg::cas_line_t line,
	output logic                   irq
);
	import cas_pkg::*;

	localparam int NP = $bits(cas_line_t);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [NP-1:0] s1_reg, s2_reg, s3_reg;
	logic [NP-1:0] filt_reg, filt_next, agree, rise;

	// a change counts once stages two and three agree
	assign agree     = ~(s2_reg ^ s3_reg);
	assign filt_next = (agree & s2_reg) | (~agree & filt_reg);
	assign rise      = filt_next & ~filt_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			filt_reg <= '0;
		end else begin
			s1_reg   <= line;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			filt_reg <= filt_next;
		end
	end

	cas_line_t lv, le;
	assign lv = cas_line_t'(filt_next);
	assign le = cas_line_t'(rise);

	// ----------------------------------------
	// control register
	// ----------------------------------------
	cas_ctrl_t ctrl_reg;
	logic      dsx_rate;
	assign dsx_rate = (ctrl_reg.rate == RATE_DS3) ||
		(ctrl_reg.rate == RATE_STS1);

	// ----------------------------------------
	// analog loss with hysteresis
	// ----------------------------------------
	logic ana_reg, ana_next;

	// two thresholds stop the bit chattering near one level
	assign ana_next = !dsx_rate ? 1'b0 :
		lv.amp_below_declare ? 1'b1 :
		lv.amp_above_clear   ? 1'b0 : ana_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ana_reg <= 1'b0;
		else
			ana_reg <= ana_next;
	end

	// ----------------------------------------
	// digital loss detector
	// ----------------------------------------
	cas_dlos_t  dst_reg, dst_next;
	logic [7:0] run_reg, run_next;
	logic [5:0] win_reg, win_next;
	logic [5:0] pls_reg, pls_next;
	logic       tick, hit;

	assign tick = le.rx_bit_tick & dsx_rate;
	assign hit  = lv.rx_pulse;

	// run counts empty bits; window measures pulse density
	always_comb begin
		dst_next = dst_reg;
		run_next = run_reg;
		win_next = win_reg;
		pls_next = pls_reg;
		case (dst_reg)
		DLOS_CLEAR: begin
			if (tick) begin
				run_next = hit ? 8'd0 : run_reg + 8'd1;
				if (!hit && run_next == `CAS_DLOS_RUN) begin
					dst_next = DLOS_DECLARED;
					win_next = 6'd0;
					pls_next = 6'd0;
				end
			end
		end
		DLOS_DECLARED: begin
			if (tick) begin
				win_next = win_reg + 6'd1;
				pls_next = pls_reg + {5'd0, hit};
				if (win_next == `CAS_DENS_WIN) begin
					win_next = 6'd0;
					pls_next = 6'd0;
					if (pls_reg + {5'd0, hit} >= `CAS_DENS_MIN) begin
						dst_next = DLOS_CLEAR;
						run_next = 8'd0;
					end
				end
			end
		end
		default: dst_next = DLOS_CLEAR;
		endcase
		if (!dsx_rate) begin
			dst_next = DLOS_CLEAR;
			run_next = 8'd0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dst_reg <= DLOS_CLEAR;
			run_reg <= 8'd0;
			win_reg <= 6'd0;
			pls_reg <= 6'd0;
		end else begin
			dst_reg <= dst_next;
			run_reg <= run_next;
			win_reg <= win_next;
			pls_reg <= pls_next;
		end
	end

	// ----------------------------------------
	// jitter attenuator fill tracking
	// ----------------------------------------
	logic [5:0] fill_reg, fill_next;
	logic       wr, rd, fl_alarm;

	assign wr = le.rx_bit_tick && fill_reg != `CAS_FIFO_DEPTH;
	assign rd = le.ja_read_tick && fill_reg != 6'd0;

	// disabled attenuator recentres so re-enable starts safe
	assign fill_next = !ctrl_reg.ja_enable ? `CAS_FIFO_MID :
		fill_reg + {5'd0, wr} - {5'd0, rd};

	assign fl_alarm = ctrl_reg.ja_enable &&
		(fill_reg <= `CAS_FIFO_MARGIN ||
		 fill_reg >= `CAS_FIFO_DEPTH - `CAS_FIFO_MARGIN);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fill_reg <= `CAS_FIFO_MID;
		else
			fill_reg <= fill_next;
	end

	// ----------------------------------------
	// lock loss: count recovered vs reference
	// ----------------------------------------
	logic        ref_tick, win_end, lol_reg, lol_next;
	logic [11:0] rcnt_reg, ccnt_reg, diff;

	assign ref_tick = ctrl_reg.single_freq_mode ?
		le.synth_ref_tick :
		(ctrl_reg.rate == RATE_E3)  ? le.e3_ref_clock_in :
		(ctrl_reg.rate == RATE_DS3) ? le.ds3_ref_clock_in :
		le.sts1_ref_clock_in;
	assign win_end = ref_tick && rcnt_reg == `CAS_LOL_WIN - 12'd1;
	assign diff    = (ccnt_reg > `CAS_LOL_WIN) ?
		ccnt_reg - `CAS_LOL_WIN : `CAS_LOL_WIN - ccnt_reg;
	// 10 counts in 2000 is 5000 ppm; verdict once per window
	assign lol_next = win_end ? (diff >= `CAS_LOL_TOL) : lol_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcnt_reg <= 12'd0;
			ccnt_reg <= 12'd0;
			lol_reg  <= 1'b0;
		end else begin
			lol_reg  <= lol_next;
			if (win_end) begin
				rcnt_reg <= 12'd0;
				ccnt_reg <= {11'd0, le.rx_bit_tick};
			end else begin
				rcnt_reg <= rcnt_reg + {11'd0, ref_tick};
				if (ccnt_reg != 12'hfff)
					ccnt_reg <= ccnt_reg + {11'd0, le.rx_bit_tick};
			end
		end
	end

	// ----------------------------------------
	// status register
	// ----------------------------------------
	logic [7:0] stat_reg, stat_next;
	logic       dig;
	assign dig = (dst_reg == DLOS_DECLARED);

	always_comb begin
		stat_next = `CAS_STATUS_RST;
		stat_next[`CAS_BIT_ALOS] = ana_reg;
		stat_next[`CAS_BIT_FL]   = fl_alarm;
		stat_next[`CAS_BIT_LOL]  = lol_reg;
		stat_next[`CAS_BIT_LOS]  = ana_reg | dig;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stat_reg <= `CAS_STATUS_RST;
		else
			stat_reg <= stat_next;
	end

	// ----------------------------------------
	// interrupts: rising alarms set sticky bits
	// ----------------------------------------
	logic [3:0] ev, isr_reg, isr_next, ien_reg, clr;

	assign ev = stat_next[4:1] & ~stat_reg[4:1];
	// a set in the clearing cycle wins
	assign isr_next = (isr_reg & ~clr) | ev;
	assign irq      = |(isr_reg & ien_reg);

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	logic        setup, wen, hit_sts, hit_ctl, hit_isr;
	logic        hit_clr, hit_ien, mapped;
	logic [31:0] rd_next;

	assign setup   = psel & ~penable;
	assign wen     = psel & penable & pwrite;
	assign hit_sts = paddr == `CAS_OFF_STATUS;
	assign hit_ctl = paddr == `CAS_OFF_CTRL;
	assign hit_isr = paddr == `CAS_OFF_IRQ_STS;
	assign hit_clr = paddr == `CAS_OFF_IRQ_CLR;
	assign hit_ien = paddr == `CAS_OFF_IRQ_EN;
	assign mapped  = hit_sts | hit_ctl | hit_isr | hit_clr | hit_ien;
	assign clr     = (wen & hit_clr) ? pwdata[3:0] : 4'h0;
	// no wait state: read data is latched in the setup cycle
	assign pready  = penable;
	assign pslverr = psel & penable & ~mapped;
	assign rd_next = hit_sts ? {24'd0, stat_next} :
		hit_ctl ? {28'd0, ctrl_reg} :
		hit_isr ? {28'd0, isr_next} :
		hit_ien ? {28'd0, ien_reg} : 32'd0;

	// status writes fall through untouched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= cas_ctrl_t'(`CAS_CTRL_RST);
			ien_reg  <= 4'h0;
			isr_reg  <= 4'h0;
			prdata   <= 32'd0;
		end else begin
			isr_reg <= isr_next;
			if (setup && !pwrite)
				prdata <= rd_next;
			if (wen && hit_ctl)
				ctrl_reg <= cas_ctrl_t'(pwdata[3:0]);
			if (wen && hit_ien)
				ien_reg <= pwdata[3:0];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_analog_bit: assert property (
		##1 stat_reg[4] == $past(ana_reg))
		else $error("analog loss bit mismatch");

	a_hyst_hold: assert property (
		ana_reg && dsx_rate && !lv.amp_above_clear |=> ana_reg)
		else $error("analog loss cleared without clear level");

	a_los_combine: assert property (
		##1 stat_reg[1] == ($past(ana_reg) || $past(dig)))
		else $error("combined loss is not the OR");

	a_fifo_set: assert property (
		ctrl_reg.ja_enable && fill_reg <= 6'd2 |=> stat_reg[3])
		else $error("fifo limit alarm missing");

	a_fifo_clear: assert property (
		fill_reg > 6'd2 && fill_reg < 6'd30 |=> !stat_reg[3])
		else $error("fifo limit alarm stuck");

	a_fifo_gate: assert property (
		!ctrl_reg.ja_enable |=> !stat_reg[3])
		else $error("fifo alarm while attenuator off");

	a_lol_judge: assert property (
		win_end && diff >= 12'd10 |=> lol_reg ##1 stat_reg[2])
		else $error("lock loss not declared");

	a_sfm_ref: assert property (
		ctrl_reg.single_freq_mode && le.synth_ref_tick && !win_end
		|=> rcnt_reg == $past(rcnt_reg) + 12'd1)
		else $error("synth tick not counted in single freq mode");

	a_dlos_run: assert property (
		dst_reg == DLOS_CLEAR && run_reg == 8'd159 && tick && !hit
		|=> dst_reg == DLOS_DECLARED ##1 stat_reg[1])
		else $error("digital loss not declared at 160");

	a_sts_write: assert property (
		wen && hit_sts |=> stat_reg == $past(stat_next) &&
		ctrl_reg == $past(ctrl_reg) && ien_reg == $past(ien_reg))
		else $error("status write had an effect");

	// the read path must carry every alarm bit, not only hold it
	a_los_read: assert property (
		setup && !pwrite && hit_sts
		|=> prdata[4:1] == $past(stat_next[4:1]))
		else $error("status read lost an alarm bit");
endmodule

/* File: verif/cas_line_model.sv */
// Purpose: line side model, makes the tick and level pins of one channel
// Assumes: periods are given in pclk cycles, at least 6, or 0 for still
// Notes:   a still tick pin rests low; levels come straight from the bench
`timescale 1ns/1ps

// ----------------------------------------
// one tick source
// ----------------------------------------
module cas_tick_gen (
	input  wire logic pclk,
	input  int        per,
	output logic      t
);
	int cnt = 0;
	int cur = 0;

	// a new period is taken only at a wrap, so no tick is cut short
	always @(posedge pclk) begin
		if (cnt + 1 >= cur) begin
			cnt <= 0;
			cur <= per;
		end else begin
			cnt <= cnt + 1;
		end
	end
	assign t = cnt < cur / 2;
endmodule

// ----------------------------------------
// channel line model
// ----------------------------------------
module cas_line_model (
	input  wire logic         pclk,
	input  int                per [6],
	input  wire logic         pulse,
	input  wire logic         amp_lo,
	input  wire logic         amp_hi,
	output cas_pkg::cas_line_t line
);
	import cas_pkg::*;
	logic [5:0] t;

	// 0 bit, 1 fifo read, 2 e3, 3 ds3, 4 sts1, 5 synthesizer
	for (genvar i = 0; i < 6; i++) begin : g_tick
		cas_tick_gen u_gen (.pclk(pclk), .per(per[i]), .t(t[i]));
	end
	assign line = {amp_lo, amp_hi, t[0], pulse, t[1], t[2], t[3], t[4],
		t[5]};
endmodule

/* File: verif/channel_alarm_status_bits_tb_top.sv */
// Purpose: self-checking bench of the channel alarm status block
// Assumes: line model drives the pins; waits follow the pin lag
// Notes:   reads note their expectation, a monitor compares on the bus
`timescale 1ns/1ps
`include "cas_params.svh"

module channel_alarm_status_bits_tb_top;
	import cas_pkg::*;
	localparam logic [11:0] st_a = `CAS_OFF_STATUS;
	localparam logic [11:0] ct_a = `CAS_OFF_CTRL;
	localparam logic [11:0] is_a = `CAS_OFF_IRQ_STS;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	cas_line_t   line;
	int          per [6] = '{default: 0};
	logic        pulse = 1'b1;
	logic        amp_lo = 1'b0;
	logic        amp_hi = 1'b0;
	int          fails = 0;
	int          tests_run = 0;
	logic [32:0] expq [$];

	always #12.5 pclk = ~pclk;

	cas_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .line(line), .irq(irq));
	cas_line_model partner (.pclk(pclk), .per(per), .pulse(pulse),
		.amp_lo(amp_lo), .amp_hi(amp_hi), .line(line));

	// ----------------------------------------
	// report, compare and bus tasks
	// ----------------------------------------
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic cmp_read(input logic [32:0] e, input logic [32:0] s);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("wrong value read expected %h seen %h", e, s);
		end
	endtask

	// irq is looked at mid-cycle, once the write edge has landed
	task automatic cmp_irq(input logic e);
		@(negedge pclk);
		tests_run++;
		if (irq !== e) begin
			fails++;
			$display("wrong value irq expected %b seen %b", e, irq);
		end
		@(posedge pclk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 40) begin
			fails++;
			close_out();
		end
	endtask

	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// monitor: each completed read takes the oldest expectation
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			cmp_read(expq.pop_front(), {pslverr, prdata});
		end
	end

	// watchdog: a hang counts as a mismatch
	initial begin
		cyc(90000);
		fails++;
		close_out();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		r = $urandom(47);
		cyc(3);
		presetn <= 1'b1;
		rd(st_a, 33'h0);
		rd(ct_a, 33'h0);
		rd(is_a, 33'h0);
		r = $urandom();
		apb(1'b1, st_a, r);
		rd(st_a, 33'h0);
		rd({2'b11, r[7:0], 2'b00}, 33'h1_0000_0000);
		// e3 keeps analog loss off; sts1 then shows and clears it
		amp_lo <= 1'b1;
		cyc(10);
		rd(st_a, 33'h0);
		apb(1'b1, ct_a, 32'h2);
		cyc(10);
		rd(st_a, 33'h12);
		amp_lo <= 1'b0;
		amp_hi <= 1'b1;
		cyc(10);
		rd(st_a, 33'h0);
		amp_hi <= 1'b0;
		// ds3 rate; analog loss with hysteresis and the interrupt path
		apb(1'b1, ct_a, 32'h1);
		rd(ct_a, 33'h1);
		amp_lo <= 1'b1;
		cyc(10);
		rd(st_a, 33'h12);
		amp_lo <= 1'b0;
		cyc(10);
		rd(st_a, 33'h12);
		cmp_irq(1'b0);
		rd(is_a, 33'h9);
		apb(1'b1, `CAS_OFF_IRQ_EN, 32'h8);
		cmp_irq(1'b1);
		apb(1'b1, `CAS_OFF_IRQ_CLR, 32'h8);
		cmp_irq(1'b0);
		amp_hi <= 1'b1;
		cyc(10);
		rd(st_a, 33'h0);
		amp_hi <= 1'b0;
		// digital loss: just short of and past 160 empty bits
		pulse <= 1'b0;
		per[0] <= 8;
		cyc(150 * 8);
		rd(st_a, 33'h0);
		cyc(20 * 8);
		rd(st_a, 33'h2);
		pulse <= 1'b1;
		cyc(70 * 8);
		rd(st_a, 33'h0);
		per[0] <= 0;
		// fifo: near overflow, back in range, near underrun, disabled
		apb(1'b1, ct_a, 32'h5);
		per[0] <= 8;
		cyc(20 * 8);
		per[0] <= 0;
		cyc(16);
		rd(st_a, 33'h8);
		per[1] <= 8;
		cyc(6 * 8);
		per[1] <= 0;
		cyc(16);
		rd(st_a, 33'h0);
		per[1] <= 8;
		cyc(40 * 8);
		per[1] <= 0;
		cyc(16);
		rd(st_a, 33'h8);
		apb(1'b1, ct_a, 32'h1);
		rd(st_a, 33'h0);
		// lock: only the ds3 pin is off rate, then the synthesizer
		per[0] <= 7;
		per[2] <= 7;
		per[3] <= 6;
		per[4] <= 7;
		cyc(25000);
		rd(st_a, 33'h4);
		apb(1'b1, ct_a, 32'h9);
		per[2] <= 0;
		per[3] <= 0;
		per[4] <= 0;
		per[5] <= 7;
		cyc(29000);
		rd(st_a, 33'h0);
		close_out();
	end
endmodule
